// ==== ivu_pkg.sv ====
// ****************************************************************
// interrupt vector unit constants
// ****************************************************************
package ivu_pkg;

    localparam int NUM_SOURCES = 32;
    localparam int SRC_BITS    = 5;
    localparam int NUM_SLOTS   = 16;
    localparam int SLOT_BITS   = 4;
    localparam int ADDR_BITS   = 32;
    localparam int CFG_SEL_BITS = 6;

    // configuration port selectors
    localparam logic [CFG_SEL_BITS-1:0] CFG_ENABLE       = 6'h00;
    localparam logic [CFG_SEL_BITS-1:0] CFG_FAST_SELECT  = 6'h01;
    localparam logic [CFG_SEL_BITS-1:0] CFG_DEFAULT_ADDR = 6'h02;
    localparam logic [1:0]              CFG_GRP_SLOT_ADDR = 2'h1; // 0x10..0x1F
    localparam logic [1:0]              CFG_GRP_SLOT_CTRL = 2'h2; // 0x20..0x2F

    // slot control word layout
    localparam int SLOT_CTRL_SRC_LSB = 0;
    localparam int SLOT_CTRL_EN_BIT  = 5;

    // reset values
    localparam logic [NUM_SOURCES-1:0] ENABLE_RESET      = 32'h0000_0000;
    localparam logic [NUM_SOURCES-1:0] FAST_SELECT_RESET = 32'h0000_0000;
    localparam logic [ADDR_BITS-1:0]   ADDR_RESET        = 32'h0000_0000;
    localparam logic [SRC_BITS-1:0]    SLOT_SRC_RESET    = 5'h00;

endpackage

// ==== ivu_slot_pick.sv ====
`timescale 1ns/10ps
// ****************************************************************
// lowest-numbered active slot finder
// ****************************************************************
module ivu_slot_pick
    import ivu_pkg::*;
(
    input  wire logic [NUM_SLOTS-1:0] slotHit,
    output logic                      anyHit,
    output logic [SLOT_BITS-1:0]      winIndex
);

    // scan from the top so the lowest index is written last and wins
    always_comb begin
        anyHit   = 1'b0;
        winIndex = '0;
        for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
            if (slotHit[i]) begin
                anyHit   = 1'b1;
                winIndex = SLOT_BITS'(i); // [R06]
            end
        end
    end

endmodule

// ==== ivu_interrupt_vector_unit.sv ====
`timescale 1ns/10ps
// How it works
// [R01] each source is classed fast, vectored normal or plain normal by configuration
// [R02] class, slot and enable settings may be rewritten at any time while running
// [R03] fast class ranks highest; all fast requests merge into one fast output
// [R04] a status word shows which fast sources are requesting right now
// [R05] sixteen vectored slots, each may point at any source
// [R06] slot zero wins, slot fifteen loses; priority falls with slot number
// [R07] vectored requests rank below fast and above non-vectored ones
// [R08] non-vectored normal requests rank lowest of all
// [R09] vectored and non-vectored normal requests merge into one normal output
// [R10] vector address gives winning slot address, else the shared default address
// [R11] a second status word shows every active normal-class request
// [R12] each peripheral drives one request line, possibly an or of its flags
// [R13] core outputs follow their enabled requests and drop once all are cleared
// [R14] after reset nothing is enabled or slotted and both outputs are low
module ivu_interrupt_vector_unit
    import ivu_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    nrst,
    // peripheral request lines, one per peripheral, level sensitive
    input  wire logic [NUM_SOURCES-1:0]  srcRequest,
    // configuration load port
    input  wire logic                    cfgWrite,
    input  wire logic [CFG_SEL_BITS-1:0] cfgSel,
    input  wire logic [ADDR_BITS-1:0]    cfgData,
    // processor core side
    output logic                         fastIrq,
    output logic                         normalIrq,
    output logic [ADDR_BITS-1:0]         vectorAddress,
    output logic                         vectorValid,
    output logic [SLOT_BITS-1:0]         vectorSlot,
    output logic [NUM_SOURCES-1:0]       fastStatus,
    output logic [NUM_SOURCES-1:0]       normalStatus,
    output logic [NUM_SOURCES-1:0]       plainStatus
);

    // ****************************************************************
    // configuration storage
    // ****************************************************************
    logic [NUM_SOURCES-1:0] enable_q;
    logic [NUM_SOURCES-1:0] fastSelect_q;
    logic [ADDR_BITS-1:0]   defaultAddr_q;
    logic [ADDR_BITS-1:0]   slotAddr_q   [NUM_SLOTS];
    logic [SRC_BITS-1:0]    slotSrc_q    [NUM_SLOTS];
    logic [NUM_SLOTS-1:0]   slotEnable_q;

    logic                   slotAddrWrite;
    logic                   slotCtrlWrite;
    logic [SLOT_BITS-1:0]   cfgSlot;

    // upper selector bits pick the group, lower ones the slot
    assign cfgSlot       = cfgSel[SLOT_BITS-1:0];
    assign slotAddrWrite = cfgWrite && (cfgSel[CFG_SEL_BITS-1:SLOT_BITS] == CFG_GRP_SLOT_ADDR);
    assign slotCtrlWrite = cfgWrite && (cfgSel[CFG_SEL_BITS-1:SLOT_BITS] == CFG_GRP_SLOT_CTRL);

    // exact selector matches for the three global settings
    logic                   enableWrite;
    logic                   fastSelWrite;
    logic                   defaultWrite;

    assign enableWrite  = cfgWrite && (cfgSel == CFG_ENABLE);
    assign fastSelWrite = cfgWrite && (cfgSel == CFG_FAST_SELECT);
    assign defaultWrite = cfgWrite && (cfgSel == CFG_DEFAULT_ADDR);

    // enable mask: a cleared bit hides its source from every output
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            enable_q <= ENABLE_RESET; // [R14]
        end else if (enableWrite) begin
            enable_q <= cfgData;      // [R02]
        end
    end

    // fast class mask; a write lands on the next edge, even mid-service
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            fastSelect_q <= FAST_SELECT_RESET; // [R14]
        end else if (fastSelWrite) begin
            fastSelect_q <= cfgData;           // [R01] [R02]
        end
    end

    // shared default routine address, used when no slot is pending
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            defaultAddr_q <= ADDR_RESET;
        end else if (defaultWrite) begin
            defaultAddr_q <= cfgData;
        end
    end

    // ****************************************************************
    // per-slot settings and slot request detection
    // ****************************************************************
    logic [NUM_SOURCES-1:0] fastActive;
    logic [NUM_SOURCES-1:0] normalActive;
    logic [NUM_SOURCES-1:0] slottedMask;
    logic [NUM_SLOTS-1:0]   slotHit;
    logic [NUM_SOURCES-1:0] slotClaim [NUM_SLOTS];

    // the fast class steals a source even if a slot also names it
    assign fastActive   = srcRequest & enable_q & fastSelect_q;   // [R01] [R03]
    assign normalActive = srcRequest & enable_q & ~fastSelect_q;  // [R01] [R07]

    genvar s;
    generate
        for (s = 0; s < NUM_SLOTS; s++) begin : gSlot
            always_ff @(posedge clk_sys) begin
                if (!nrst) begin
                    slotAddr_q[s]   <= ADDR_RESET;
                    slotSrc_q[s]    <= SLOT_SRC_RESET;
                    slotEnable_q[s] <= 1'b0; // [R14]
                end else begin
                    if (slotAddrWrite && (cfgSlot == SLOT_BITS'(s))) begin
                        slotAddr_q[s] <= cfgData;
                    end
                    if (slotCtrlWrite && (cfgSlot == SLOT_BITS'(s))) begin
                        slotSrc_q[s]    <= cfgData[SLOT_CTRL_SRC_LSB +: SRC_BITS]; // [R05] [R02]
                        slotEnable_q[s] <= cfgData[SLOT_CTRL_EN_BIT];
                    end
                end
            end

            // a slot fires when its enabled source is an active normal request
            assign slotHit[s] = slotEnable_q[s] && normalActive[slotSrc_q[s]]; // [R05]

            // one-hot claim so the non-vectored set can exclude slotted sources
            if (s == 0) begin : gFirst
                assign slotClaim[s] = slotEnable_q[s] ?
                                      (NUM_SOURCES'(1) << slotSrc_q[s]) : '0;
            end else begin : gNext
                assign slotClaim[s] = slotClaim[s-1] | (slotEnable_q[s] ?
                                      (NUM_SOURCES'(1) << slotSrc_q[s]) : '0);
            end
        end
    endgenerate

    assign slottedMask = slotClaim[NUM_SLOTS-1];

    // ****************************************************************
    // vectored priority resolution
    // ****************************************************************
    logic                 anyVectored;
    logic [SLOT_BITS-1:0] winSlot;

    ivu_slot_pick uPick (
        .slotHit  (slotHit),
        .anyHit   (anyVectored),
        .winIndex (winSlot)
    );

    // ****************************************************************
    // core-facing outputs
    // ****************************************************************
    logic                 anyFast;
    logic                 anyNormal;

    // one wide or per class; vectored and plain both feed the normal line
    assign anyFast   = |fastActive;   // [R03]
    assign anyNormal = |normalActive; // [R09]

    // outputs are level images of the requests: no latching, so an
    // output drops one edge after the last source releases its line
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            fastIrq <= 1'b0; // [R14]
        end else begin
            fastIrq <= anyFast; // [R13]
        end
    end

    // normal line to the core, same latency as the fast one
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            normalIrq <= 1'b0; // [R14]
        end else begin
            normalIrq <= anyNormal; // [R13]
        end
    end

    // fast status word, read by the fast routine to find its sources
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            fastStatus <= '0;
        end else begin
            fastStatus <= fastActive; // [R04]
        end
    end

    // every enabled normal request, vectored or not
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            normalStatus <= '0;
        end else begin
            normalStatus <= normalActive; // [R11]
        end
    end

    // normal requests no enabled slot claims; a disabled slot claims nothing,
    // so its source stays visible to the default routine
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            plainStatus <= '0;
        end else begin
            plainStatus <= normalActive & ~slottedMask; // [R08]
        end
    end

    // vector address: winning slot first, default routine otherwise
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            vectorAddress <= ADDR_RESET;
            vectorValid   <= 1'b0;
            vectorSlot    <= '0;
        end else begin
            vectorValid <= anyVectored;
            vectorSlot  <= winSlot;
            if (anyVectored) begin
                vectorAddress <= slotAddr_q[winSlot]; // [R10] [R07]
            end else begin
                vectorAddress <= defaultAddr_q;       // [R10] [R08]
            end
        end
    end

endmodule

// ==== ivu_asserts.sv ====
`timescale 1ns/10ps
// ****************************************************************
// port checker
// ****************************************************************
module ivu_checker
    import ivu_pkg::*;
(
    input wire logic                   clk_sys,
    input wire logic                   nrst,
    input wire logic [NUM_SOURCES-1:0] srcRequest,
    input wire logic                   fastIrq,
    input wire logic                   normalIrq,
    input wire logic                   vectorValid,
    input wire logic [SLOT_BITS-1:0]   vectorSlot,
    input wire logic [NUM_SOURCES-1:0] fastStatus,
    input wire logic [NUM_SOURCES-1:0] normalStatus,
    input wire logic [NUM_SOURCES-1:0] plainStatus
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // outputs are registered together, so merges hold in the same cycle
    a_fast_merge: assert property (fastIrq == |fastStatus) else $error("fast merge");
    a_norm_merge: assert property (normalIrq == |normalStatus) else $error("norm merge");
    a_class_split: assert property ((fastStatus & normalStatus) == '0)
        else $error("two classes");
    a_plain_inside: assert property ((plainStatus & ~normalStatus) == '0)
        else $error("plain outside");
    a_vec_normal: assert property (vectorValid |-> normalIrq) else $error("vec no irq");
    a_idle_slot: assert property (!vectorValid |-> vectorSlot == '0) else $error("slot");
    // status may only show a line that was high one edge before
    a_req_cause: assert property (
        ((fastStatus | normalStatus) & ~$past(srcRequest)) == '0) else $error("no cause");
    a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> !fastIrq && !normalIrq)
        else $error("reset irq");
    c_fast: cover property (fastIrq);
    c_last: cover property (vectorValid && vectorSlot == 4'hF);
    c_plain: cover property (vectorValid && plainStatus != '0);
endmodule
bind ivu_interrupt_vector_unit ivu_checker u_chk (.clk_sys, .nrst, .srcRequest, .fastIrq,
    .normalIrq, .vectorValid, .vectorSlot, .fastStatus, .normalStatus, .plainStatus);

// ==== ivu_periph_model.sv ====
`timescale 1ns/10ps
// ****************************************************************
// peripheral side
// ****************************************************************
module ivu_periph_model
    import ivu_pkg::*;
(
    input  wire logic [NUM_SOURCES-1:0] flagA,
    input  wire logic [NUM_SOURCES-1:0] flagB,
    output logic      [NUM_SOURCES-1:0] srcRequest
);
    // each peripheral owns one line, the or of its two flags
    assign srcRequest = flagA | flagB;
endmodule

// ==== vectored_interrupt_controller_tb_top.sv ====
`timescale 1ns/10ps
// ****************************************************************
// bench
// ****************************************************************
module vectored_interrupt_controller_tb_top
    import ivu_pkg::*;
;
    logic        clk_sys, nrst, cfgWrite, fastIrq, normalIrq, vectorValid;
    logic [5:0]  cfgSel;
    logic [3:0]  vectorSlot;
    logic [31:0] cfgData, vectorAddress, flagA, flagB, srcRequest;
    logic [31:0] fastStatus, normalStatus, plainStatus, en, fs, da, sa[16], ss[16], sv[16];
    int          fails, num_checks, k;
    ivu_periph_model peri (.flagA, .flagB, .srcRequest);
    ivu_interrupt_vector_unit dut (.clk_sys, .nrst, .srcRequest, .cfgWrite, .cfgSel,
        .cfgData, .fastIrq, .normalIrq, .vectorAddress, .vectorValid, .vectorSlot,
        .fastStatus, .normalStatus, .plainStatus);
    always #2 clk_sys = ~clk_sys;
    task automatic chk(input string w, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic init_model;
        {en, fs, da} = '0;
        for (int n = 0; n < 16; n++) {sa[n], ss[n], sv[n]} = '0;
    endtask
    // one write, mirrored in the model; unmapped selectors change nothing
    task automatic cfg(input logic [5:0] sel, input logic [31:0] d);
        @(posedge clk_sys);
        {cfgWrite, cfgSel, cfgData} <= {1'b1, sel, d};
        if (sel == CFG_ENABLE) en = d;
        else if (sel == CFG_FAST_SELECT) fs = d;
        else if (sel == CFG_DEFAULT_ADDR) da = d;
        else if (sel[5:4] == CFG_GRP_SLOT_ADDR) sa[sel[3:0]] = d;
        else if (sel[5:4] == CFG_GRP_SLOT_CTRL) {sv[sel[3:0]], ss[sel[3:0]]} = {d[5], 27'h0, d[4:0]};
        @(posedge clk_sys);
        cfgWrite <= 1'b0;
    endtask
    // three edges cover the two-edge config delay and the one-edge request delay
    task automatic expect_all;
        logic [31:0] fe, ne, nm;
        int w;
        repeat (3) @(posedge clk_sys);
        #1;
        fe = (flagA | flagB) & en & fs;
        ne = (flagA | flagB) & en & ~fs;
        nm = '0;
        w = -1;
        for (int n = 15; n >= 0; n--) if (sv[n][0]) begin
            nm[ss[n]] = 1'b1;
            if (ne[ss[n]]) w = n;
        end
        chk("fastIrq", fastIrq, |fe);
        chk("fastStatus", fastStatus, fe);
        chk("normalIrq", normalIrq, |ne);
        chk("normalStatus", normalStatus, ne);
        chk("plainStatus", plainStatus, ne & ~nm);
        chk("vectorValid", vectorValid, w >= 0);
        chk("vectorSlot", vectorSlot, w < 0 ? 0 : w);
        chk("vectorAddress", vectorAddress, w < 0 ? da : sa[w]);
        // hand back on a rising edge so the next drive lands there too
        @(posedge clk_sys);
    endtask
    task automatic close_out;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        {clk_sys, nrst, cfgWrite, cfgSel, cfgData, flagB} = '0;
        flagA = '1;
        init_model();
        k = $urandom(63);
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        expect_all();
        $display("test reset done");
        flagA <= '0;
        cfg(CFG_ENABLE, 32'hFFFF_FFFF);
        cfg(CFG_DEFAULT_ADDR, 32'h0000_DEF0);
        for (k = 0; k < 16; k++) cfg({2'h2, 4'(k)}, 32'h20 + 32'(k));
        for (k = 0; k < 16; k++) cfg({2'h1, 4'(k)}, 32'h100 * 32'(k + 1));
        for (k = 15; k >= 0; k--) begin
            flagB <= 32'hFFFF_FFFF << k;
            expect_all();
        end
        flagB <= '0;
        expect_all();
        $display("test slots done");
        // settings rewritten while requests stand
        for (int t = 0; t < 48; t++) begin
            if (t % 6 == 0) begin
                cfg(CFG_FAST_SELECT, $urandom & $urandom);
                cfg(CFG_ENABLE, $urandom | $urandom);
                cfg({2'h2, 4'($urandom)}, $urandom & 32'h3F);
                cfg({2'h1, 4'($urandom)}, $urandom);
                cfg({2'h3, 4'($urandom)}, $urandom);
            end
            flagA <= $urandom & $urandom & $urandom;
            flagB <= $urandom & $urandom;
            expect_all();
        end
        $display("test random done");
        nrst <= 1'b0;
        init_model();
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        expect_all();
        $display("test rereset done");
        close_out();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        close_out();
    end
endmodule
